// ==== design/cedc_params.svh ====
// Constants for the CAN error detection and confinement block.
// Assumes inclusion by bare name from the core; the package does not include it.
`ifndef CEDC_PARAMS_SVH
`define CEDC_PARAMS_SVH

// ********************************
// Register offsets
// ********************************
`define CEDC_ADDR_TEC 8'h1C
`define CEDC_ADDR_REC 8'h1D
`define CEDC_ADDR_ERROR_FLAG_REGISTER 8'h2D
`define CEDC_ADDR_IRQ_STAT 8'h30
`define CEDC_ADDR_IRQ_CLR 8'h31
`define CEDC_ADDR_IRQ_EN 8'h32
`define CEDC_ADDR_LAST_ERR 8'h33

// ********************************
// Error flag register fields
// ********************************
`define CEDC_ERROR_FLAG_REGISTER_RX1OVF 7
`define CEDC_ERROR_FLAG_REGISTER_RX0OVF 6
`define CEDC_ERROR_FLAG_REGISTER_BUSOFF 5
`define CEDC_ERROR_FLAG_REGISTER_TXPAS 4
`define CEDC_ERROR_FLAG_REGISTER_RXPAS 3
`define CEDC_ERROR_FLAG_REGISTER_TXWARN 2
`define CEDC_ERROR_FLAG_REGISTER_RXWARN 1
`define CEDC_ERROR_FLAG_REGISTER_ERROR_WARNING_FLAG 0

// ********************************
// Interrupt status fields
// ********************************
`define CEDC_IRQ_ERR 0
`define CEDC_IRQ_MODE 1
`define CEDC_IRQ_OVF 2
`define CEDC_IRQ_RECOV 3
`define CEDC_IRQ_W 4

// ********************************
// Reset values, limits and protocol constants
// ********************************
`define CEDC_RST_BYTE 8'h00
`define CEDC_RST_IRQ 4'h0
`define CEDC_LIM_WARN 9'h060
`define CEDC_LIM_PASSIVE 9'h080
`define CEDC_LIM_BUSOFF 9'h100
`define CEDC_LIM_BOFLAG 9'h0FF
`define CEDC_TX_ERR_STEP 9'h008
`define CEDC_REC_RELOAD 9'h078
`define CEDC_CRC_POLY 15'h4599
`define CEDC_STUFF_RUN 3'h6
`define CEDC_RUN_LEN 11
`define CEDC_RUN_COUNT 128

`endif

// ==== design/cedc_pkg.sv ====
// Types for the CAN error detection and confinement block.
// Assumes cedc_params.svh sits beside it.
package cedc_pkg;

    // Frame segment reported by the protocol engine
    typedef enum logic [3:0] {
        CEDC_F_IDLE = 4'h0,
        CEDC_F_SOF = 4'h1,
        CEDC_F_ARB = 4'h2,
        CEDC_F_CTRL = 4'h3,
        CEDC_F_DATA = 4'h4,
        CEDC_F_CRC = 4'h5,
        CEDC_F_CRC_DELIM = 4'h6,
        CEDC_F_ACK_SLOT = 4'h7,
        CEDC_F_ACK_DELIM = 4'h8,
        CEDC_F_EOF = 4'h9,
        CEDC_F_IFS = 4'hA,
        CEDC_F_ERROR = 4'hB
    } cedc_field_e;

    // Fault confinement state
    typedef enum logic [1:0] {
        CEDC_M_ACTIVE = 2'b00,
        CEDC_M_PASSIVE = 2'b01,
        CEDC_M_BUSOFF = 2'b10
    } cedc_mode_e;

    // Bit context from the protocol engine, valid with bit_tick
    typedef struct packed {
        cedc_field_e field;
        logic tx_active;
        logic tx_bit;
        logic stuff_bit;
    } cedc_bit_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cedc_reg_req_s;

    // Error kinds seen in one bit
    typedef struct packed {
        logic crc_err;
        logic ack_err;
        logic form_err;
        logic bit_err;
        logic stuff_err;
    } cedc_err_s;

endpackage

// ==== design/cedc_core.sv ====
// CAN error detection and fault confinement core.
// Assumes a protocol engine on sys_clk giving one bit_tick per sample
// point with the frame context; the bus level arrives from the pin.
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "cedc_params.svh"

module cedc_core #(
    parameter int RUN_LEN = `CEDC_RUN_LEN,
    parameter int RUN_COUNT = `CEDC_RUN_COUNT
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic can_rx_pin,
    input wire logic bit_tick,
    input wire cedc_pkg::cedc_bit_s bit_ctx,
    input wire logic tx_frame_ok,
    input wire logic rx_frame_ok,
    input wire logic rx_store,
    input wire logic rx_store_buf,
    input wire logic rx_buffer0_full_flag,
    input wire logic rx_buffer1_full_flag,
    input wire cedc_pkg::cedc_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    output logic error_frame_req,
    output logic error_frame_recessive,
    output logic retransmit_req,
    output logic bus_off,
    output logic irq
);

    // ********************************
    // Elaboration checks
    // ********************************
    initial begin
        if (RUN_LEN < 2 || RUN_LEN > 255) begin
            $error("RUN_LEN out of range");
        end
        if (RUN_COUNT < 1 || RUN_COUNT > 65535) begin
            $error("RUN_COUNT out of range");
        end
    end

    // ********************************
    // Bus level synchroniser
    // ********************************
    logic rx_meta;
    logic rx_lvl;

    // Two flops before any logic sees the pin
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_meta <= 1'b1;
            rx_lvl <= 1'b1;
        end else begin
            rx_meta <= can_rx_pin;
            rx_lvl <= rx_meta;
        end
    end

    // ********************************
    // State declarations
    // ********************************
    logic [8:0] transmit_error_counter;
    logic [8:0] receive_error_counter;
    cedc_pkg::cedc_mode_e mode;
    logic [14:0] crc;
    logic crc_bad;
    logic run_lvl;
    logic [2:0] run_len;
    logic [7:0] rec_run;
    logic [15:0] rec_occ;
    logic rx1_ovf;
    logic rx0_ovf;
    logic bo_flag;
    logic [`CEDC_IRQ_W-1:0] irq_stat;
    logic [`CEDC_IRQ_W-1:0] irq_en;
    logic [4:0] last_err;

    // ********************************
    // Field decode
    // ********************************
    wire cedc_pkg::cedc_field_e fld = bit_ctx.field;
    wire in_crc_span = (fld == cedc_pkg::CEDC_F_SOF) ||
        (fld == cedc_pkg::CEDC_F_ARB) || (fld == cedc_pkg::CEDC_F_CTRL) ||
        (fld == cedc_pkg::CEDC_F_DATA);
    wire in_stuff_span = in_crc_span || (fld == cedc_pkg::CEDC_F_CRC) ||
        (fld == cedc_pkg::CEDC_F_CRC_DELIM);
    wire in_frame = in_stuff_span || (fld == cedc_pkg::CEDC_F_ACK_SLOT) ||
        (fld == cedc_pkg::CEDC_F_ACK_DELIM) || (fld == cedc_pkg::CEDC_F_EOF);
    wire fixed_form = (fld == cedc_pkg::CEDC_F_CRC_DELIM) ||
        (fld == cedc_pkg::CEDC_F_ACK_DELIM) ||
        (fld == cedc_pkg::CEDC_F_EOF) || (fld == cedc_pkg::CEDC_F_IFS);
    wire arb_or_ack = (fld == cedc_pkg::CEDC_F_ARB) ||
        (fld == cedc_pkg::CEDC_F_ACK_SLOT);
    wire is_bus_off = (mode == cedc_pkg::CEDC_M_BUSOFF);
    wire live = bit_tick && !is_bus_off;

    // ********************************
    // CRC and stuff tracking
    // ********************************
    wire crc_fb = rx_lvl ^ crc[14];
    wire [14:0] crc_shift = {crc[13:0], 1'b0} ^
        (crc_fb ? `CEDC_CRC_POLY : 15'h0000);
    wire next_run_same = (rx_lvl == run_lvl) && (fld != cedc_pkg::CEDC_F_SOF);
    wire [2:0] next_run = next_run_same ? run_len + 3'h1 : 3'h1;

    // CRC over arbitration, control and data bits, compare in CRC field, stuff run length
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            crc <= 15'h0000;
            crc_bad <= 1'b0;
            run_lvl <= 1'b1;
            run_len <= 3'h0;
        end else if (bit_tick) begin
            if (fld == cedc_pkg::CEDC_F_SOF) begin
                crc <= 15'h0000;
                crc_bad <= 1'b0;
            end else if (in_crc_span && !bit_ctx.stuff_bit) begin
                crc <= crc_shift;
            end else if (fld == cedc_pkg::CEDC_F_CRC && !bit_ctx.stuff_bit) begin
                crc_bad <= crc_bad | (rx_lvl != crc[14]);
                crc <= {crc[13:0], 1'b0};
            end
            run_lvl <= rx_lvl;
            run_len <= in_stuff_span ? next_run : 3'h0;
        end
    end

    // ********************************
    // Error detection
    // ********************************
    cedc_pkg::cedc_err_s err;
    assign err.crc_err = !bit_ctx.tx_active &&
        (fld == cedc_pkg::CEDC_F_CRC_DELIM) && crc_bad;
    assign err.ack_err = bit_ctx.tx_active &&
        (fld == cedc_pkg::CEDC_F_ACK_SLOT) && rx_lvl;
    assign err.form_err = fixed_form && !rx_lvl;
    assign err.bit_err = bit_ctx.tx_active && in_frame &&
        (fld != cedc_pkg::CEDC_F_ACK_SLOT || !bit_ctx.tx_bit) &&
        (bit_ctx.tx_bit != rx_lvl) &&
        !(bit_ctx.tx_bit && !rx_lvl && arb_or_ack);
    assign err.stuff_err = in_stuff_span && (next_run == `CEDC_STUFF_RUN) &&
        (fld != cedc_pkg::CEDC_F_CRC_DELIM || !rx_lvl);
    wire any_err = live && (err != 5'h00);
    wire tx_err = any_err && bit_ctx.tx_active;
    wire rx_err = any_err && !bit_ctx.tx_active;
    wire passive_ack = tx_err && err.ack_err && !err.bit_err &&
        (mode == cedc_pkg::CEDC_M_PASSIVE);

    // ********************************
    // Error counters
    // ********************************
    wire run_hit = live ? 1'b0 : (bit_tick && rx_lvl &&
        (rec_run == 8'(RUN_LEN - 1)));
    wire recover = run_hit && (rec_occ == 16'(RUN_COUNT - 1));
    wire [8:0] tec_up = (transmit_error_counter + `CEDC_TX_ERR_STEP > `CEDC_LIM_BUSOFF) ?
        `CEDC_LIM_BUSOFF : transmit_error_counter + `CEDC_TX_ERR_STEP;
    wire [8:0] rec_up = (receive_error_counter == 9'h0FF) ? receive_error_counter : receive_error_counter + 9'h001;
    logic [8:0] next_tec;
    logic [8:0] next_rec;

    // Fault confinement counting
    always_comb begin
        next_tec = transmit_error_counter;
        next_rec = receive_error_counter;
        if (recover) begin
            next_tec = 9'h000;
            next_rec = 9'h000;
        end else if (!is_bus_off) begin
            if (tx_err && !passive_ack) begin
                next_tec = tec_up;
            end else if (rx_err) begin
                next_rec = rec_up;
            end else if (tx_frame_ok && transmit_error_counter != 9'h000) begin
                next_tec = transmit_error_counter - 9'h001;
            end else if (rx_frame_ok) begin
                if (receive_error_counter > `CEDC_LIM_PASSIVE - 9'h001) begin
                    next_rec = `CEDC_REC_RELOAD;
                end else if (receive_error_counter != 9'h000) begin
                    next_rec = receive_error_counter - 9'h001;
                end
            end
        end
    end

    // Counters clear at power-on
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            transmit_error_counter <= 9'h000;
            receive_error_counter <= 9'h000;
        end else begin
            transmit_error_counter <= next_tec;
            receive_error_counter <= next_rec;
        end
    end

    // ********************************
    // Error mode and bus-off recovery
    // ********************************
    wire tx_pas = transmit_error_counter >= `CEDC_LIM_PASSIVE;
    wire rx_pas = receive_error_counter >= `CEDC_LIM_PASSIVE;
    cedc_pkg::cedc_mode_e next_mode;

    // Mode from counter thresholds
    always_comb begin
        next_mode = mode;
        unique case (mode)
            cedc_pkg::CEDC_M_ACTIVE, cedc_pkg::CEDC_M_PASSIVE: begin
                if (next_tec >= `CEDC_LIM_BUSOFF) begin
                    next_mode = cedc_pkg::CEDC_M_BUSOFF;
                end else if (next_tec >= `CEDC_LIM_PASSIVE ||
                    next_rec >= `CEDC_LIM_PASSIVE) begin
                    next_mode = cedc_pkg::CEDC_M_PASSIVE;
                end else begin
                    next_mode = cedc_pkg::CEDC_M_ACTIVE;
                end
            end
            cedc_pkg::CEDC_M_BUSOFF: begin
                if (recover) begin
                    next_mode = cedc_pkg::CEDC_M_ACTIVE;
                end
            end
            default: next_mode = cedc_pkg::CEDC_M_ACTIVE;
        endcase
    end

    // Mode register and recessive run counting in bus-off
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode <= cedc_pkg::CEDC_M_ACTIVE;
            rec_run <= 8'h00;
            rec_occ <= 16'h0000;
        end else begin
            mode <= next_mode;
            if (!is_bus_off || recover) begin
                rec_run <= 8'h00;
                rec_occ <= 16'h0000;
            end else if (bit_tick) begin
                if (!rx_lvl) begin
                    rec_run <= 8'h00;
                end else if (run_hit) begin
                    rec_run <= 8'h00;
                    rec_occ <= rec_occ + 16'h0001;
                end else begin
                    rec_run <= rec_run + 8'h01;
                end
            end
        end
    end

    // ********************************
    // Register port decode
    // ********************************
    wire wr_error_flag_register = reg_req.wr && (reg_req.addr == `CEDC_ADDR_ERROR_FLAG_REGISTER);
    wire wr_clr = reg_req.wr && (reg_req.addr == `CEDC_ADDR_IRQ_CLR);
    wire wr_en = reg_req.wr && (reg_req.addr == `CEDC_ADDR_IRQ_EN);
    wire [7:0] tec_rd = (transmit_error_counter > 9'h0FF) ? 8'hFF : transmit_error_counter[7:0];
    // Arrival into a still-full buffer marks overflow
    wire set_ovf1 = rx_store && rx_store_buf &&
        rx_buffer1_full_flag;
    wire set_ovf0 = rx_store && !rx_store_buf &&
        rx_buffer0_full_flag;
    wire [7:0] error_flag_register = {rx1_ovf, rx0_ovf, bo_flag, tx_pas, rx_pas,
        transmit_error_counter >= `CEDC_LIM_WARN, receive_error_counter >= `CEDC_LIM_WARN,
        transmit_error_counter >= `CEDC_LIM_WARN || receive_error_counter >= `CEDC_LIM_WARN};
    logic [7:0] rd_mux;

    // Read selection, no read side effects
    always_comb begin
        unique case (reg_req.addr)
            `CEDC_ADDR_TEC: rd_mux = tec_rd;
            `CEDC_ADDR_REC: rd_mux = receive_error_counter[7:0];
            `CEDC_ADDR_ERROR_FLAG_REGISTER: rd_mux = error_flag_register;
            `CEDC_ADDR_IRQ_STAT: rd_mux = {4'h0, irq_stat};
            `CEDC_ADDR_IRQ_EN: rd_mux = {4'h0, irq_en};
            `CEDC_ADDR_LAST_ERR: rd_mux = {3'h0, last_err};
            default: rd_mux = 8'h00;
        endcase
    end

    // ********************************
    // Flags and interrupts
    // ********************************
    wire [`CEDC_IRQ_W-1:0] irq_evt = {recover, set_ovf0 | set_ovf1,
        next_mode != mode, any_err};

    // Sticky flags; a set in the clear cycle wins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx1_ovf <= 1'b0;
            rx0_ovf <= 1'b0;
            bo_flag <= 1'b0;
            irq_stat <= `CEDC_RST_IRQ;
            irq_en <= `CEDC_RST_IRQ;
            last_err <= 5'h00;
        end else begin
            rx1_ovf <= set_ovf1 |
                (rx1_ovf & ~(wr_error_flag_register & ~reg_req.wdata[`CEDC_ERROR_FLAG_REGISTER_RX1OVF]));
            rx0_ovf <= set_ovf0 |
                (rx0_ovf & ~(wr_error_flag_register & ~reg_req.wdata[`CEDC_ERROR_FLAG_REGISTER_RX0OVF]));
            if (next_tec >= `CEDC_LIM_BOFLAG) begin
                bo_flag <= 1'b1;
            end else if (recover) begin
                bo_flag <= 1'b0;
            end
            irq_stat <= irq_evt |
                (irq_stat & ~(wr_clr ? reg_req.wdata[3:0] : 4'h0));
            if (wr_en) begin
                irq_en <= reg_req.wdata[3:0];
            end
            if (any_err) begin
                last_err <= err;
            end
        end
    end

    // ********************************
    // Registered outputs
    // ********************************
    // Error frame request, style and retransmission
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= `CEDC_RST_BYTE;
            error_frame_req <= 1'b0;
            error_frame_recessive <= 1'b0;
            retransmit_req <= 1'b0;
            bus_off <= 1'b0;
            irq <= 1'b0;
        end else begin
            reg_rdata <= reg_req.rd ? rd_mux : `CEDC_RST_BYTE;
            error_frame_req <= any_err;
            error_frame_recessive <= next_mode != cedc_pkg::CEDC_M_ACTIVE;
            retransmit_req <= tx_err;
            bus_off <= next_mode == cedc_pkg::CEDC_M_BUSOFF;
            irq <= |(irq_evt | (irq_stat & irq_en)) && |(irq_stat & irq_en)
                || |(irq_evt & irq_en);
        end
    end

endmodule

// ==== testbench/cedc_node_model.sv ====
// Behavioural model of the other nodes sharing the CAN bus.
// Assumes the bench gives the core's own drive level and frame field.
`timescale 1ns/100ps

module cedc_node_model (
    input wire logic own_level,
    input wire cedc_pkg::cedc_field_e field,
    input wire logic ack_en,
    input wire logic force_dom,
    output logic bus_level
);
    // ********************************
    // Wired-AND bus
    // ********************************
    // Peers acknowledge in the slot when told to
    wire peer_ack = ack_en && field == cedc_pkg::CEDC_F_ACK_SLOT;
    // Any dominant driver wins the line
    assign bus_level = own_level & ~peer_ack & ~force_dom;
endmodule

// ==== testbench/cedc_core_chk.sv ====
// Port-level assertions for the error detection core.
// Assumes binding into cedc_core; sees only its ports.
`timescale 1ns/100ps

module cedc_core_chk #(
    parameter int RUN_LEN = 11,
    parameter int RUN_COUNT = 128
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic can_rx_pin,
    input wire logic bit_tick,
    input wire cedc_pkg::cedc_bit_s bit_ctx,
    input wire logic tx_frame_ok,
    input wire logic rx_frame_ok,
    input wire logic rx_store,
    input wire logic rx_store_buf,
    input wire logic rx_buffer0_full_flag,
    input wire logic rx_buffer1_full_flag,
    input wire cedc_pkg::cedc_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic error_frame_req,
    input wire logic error_frame_recessive,
    input wire logic retransmit_req,
    input wire logic bus_off,
    input wire logic irq
);
    // ********************************
    // Settled bus level history
    // ********************************
    logic [2:0] hist;
    // Three samples alike means the synced level is that value
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hist <= 3'h7;
        end else begin
            hist <= {hist[1:0], can_rx_pin};
        end
    end
    wire rec3 = &hist;
    wire dom3 = ~|hist;
    wire tk = bit_tick && !bus_off;
    cedc_pkg::cedc_field_e fld;
    assign fld = bit_ctx.field;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_rdata_quiet: assert property (!$past(reg_req.rd) |->
        reg_rdata == 8'h00) else $error("read data outside slot");
    a_retx_pair: assert property (retransmit_req |->
        error_frame_req) else $error("retransmit without error");
    a_err_cause: assert property (error_frame_req |->
        $past(bit_tick)) else $error("error frame without bit");
    a_busoff_passive: assert property (bus_off |->
        error_frame_recessive) else $error("bus-off not passive");
    a_busoff_mute: assert property (bus_off && $past(bus_off, 2)
        |-> !error_frame_req) else $error("error frame in bus-off");
    a_ack_miss: assert property (tk && bit_ctx.tx_active &&
        fld == cedc_pkg::CEDC_F_ACK_SLOT && rec3 |=> error_frame_req
        && retransmit_req) else $error("missed ack error");
    a_form_dom: assert property (tk && dom3 && fld inside
        {cedc_pkg::CEDC_F_CRC_DELIM, cedc_pkg::CEDC_F_ACK_DELIM,
        cedc_pkg::CEDC_F_EOF, cedc_pkg::CEDC_F_IFS} |=> error_frame_req)
        else $error("missed form error");
    a_bit_diff: assert property (tk && bit_ctx.tx_active &&
        fld == cedc_pkg::CEDC_F_DATA && bit_ctx.tx_bit && dom3
        |=> error_frame_req && retransmit_req) else $error("missed bit err");
    a_arb_lost: assert property (tk && bit_ctx.tx_active &&
        fld == cedc_pkg::CEDC_F_ARB && bit_ctx.tx_bit && dom3
        |=> !error_frame_req) else $error("arbitration loss flagged");
endmodule

bind cedc_core cedc_core_chk #(.RUN_LEN(RUN_LEN), .RUN_COUNT(RUN_COUNT))
    u_chk (.sys_clk, .rstn, .can_rx_pin, .bit_tick, .bit_ctx,
    .tx_frame_ok, .rx_frame_ok, .rx_store, .rx_store_buf,
    .rx_buffer0_full_flag, .rx_buffer1_full_flag, .reg_req, .reg_rdata,
    .error_frame_req, .error_frame_recessive, .retransmit_req, .bus_off,
    .irq);

// ==== testbench/can_error_detect_confinement_test.sv ====
// Self-checking bench for the error detection core.
// Assumes the core, its package and the node model are compiled first.
`timescale 1ns/100ps

module can_error_detect_confinement_test;
    logic sys_clk = 1'b0, rstn = 1'b0, tick_r = 1'b0, txok = 1'b0;
    logic rxok = 1'b0, st = 1'b0, stb = 1'b0, f0 = 1'b0, f1 = 1'b0;
    logic ack_en = 1'b0, odom = 1'b0, own = 1'b1;
    logic [1:0] ovf = 2'b00;
    cedc_pkg::cedc_bit_s ctx = '0;
    cedc_pkg::cedc_reg_req_s rq = '0;
    wire pin;
    logic [7:0] rdata;
    logic efr, efrr, retx, bus_off, irq;
    int n_errors = 0, checks = 0, transmit_error_counter = 0, receive_error_counter = 0;
    int unsigned n;
    // ********************************
    // Clock, partner and core
    // ********************************
    always #2 sys_clk = ~sys_clk;
    cedc_node_model node (.own_level(own), .field(ctx.field),
        .ack_en(ack_en), .force_dom(odom), .bus_level(pin));
    cedc_core #(.RUN_LEN(3), .RUN_COUNT(2)) dut (.sys_clk(sys_clk),
        .rstn(rstn), .can_rx_pin(pin), .bit_tick(tick_r), .bit_ctx(ctx),
        .tx_frame_ok(txok), .rx_frame_ok(rxok), .rx_store(st),
        .rx_store_buf(stb), .rx_buffer0_full_flag(f0),
        .rx_buffer1_full_flag(f1), .reg_req(rq), .reg_rdata(rdata),
        .error_frame_req(efr), .error_frame_recessive(efrr),
        .retransmit_req(retx), .bus_off(bus_off), .irq(irq));

    task automatic complete_run();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] a, e);
        checks++;
        if (a !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %0h exp %0h", $time, a, e);
        end
    endtask
    task automatic cmp1(input logic a, e);
        checks++;
        if (a !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %0h exp %0h", $time, a, e);
        end
    endtask
    // Expected flags and CRC
    function automatic logic [7:0] error_flag_register(input int t, r);
        return {ovf, t >= 255, t >= 128, r >= 128, t >= 96, r >= 96,
            t >= 96 || r >= 96};
    endfunction
    function automatic logic [14:0] crc8(input logic [7:0] d);
        logic [14:0] c = 15'h0000;
        for (int i = 7; i >= 0; i--) begin
            c = {c[13:0], 1'b0} ^ ((d[i] ^ c[14]) ? 15'h4599 : 15'h0000);
        end
        return c;
    endfunction
    // Register port cycles
    task automatic rd(input logic [7:0] a, e);
        @(posedge sys_clk);
        rq.addr <= a;
        rq.rd <= 1'b1;
        @(posedge sys_clk);
        rq.rd <= 1'b0;
        #1 cmp8(rdata, e);
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        rq.addr <= a;
        rq.wdata <= d;
        rq.wr <= 1'b1;
        @(posedge sys_clk);
        rq.wr <= 1'b0;
    endtask
    task automatic strobe(input int k);
        @(posedge sys_clk);
        txok <= k == 0;
        rxok <= k == 1;
        st <= k == 2;
        @(posedge sys_clk);
        {txok, rxok, st} <= 3'h0;
    endtask
    // One bit: settle the bus, tick, then expect the error pulse
    task automatic tick(input cedc_pkg::cedc_field_e f,
        input logic ta, tb, sb, od, ee);
        @(posedge sys_clk);
        ctx <= '{f, ta, tb, sb};
        own <= ta ? tb : 1'b1;
        odom <= od;
        repeat (3) @(posedge sys_clk);
        tick_r <= 1'b1;
        @(posedge sys_clk);
        tick_r <= 1'b0;
        #1 cmp1(efr, ee);
        cmp1(retx, ee & ta);
    endtask
    task automatic state();
        rd(8'h1C, transmit_error_counter > 255 ? 8'hFF : 8'(transmit_error_counter));
        rd(8'h1D, 8'(receive_error_counter));
        rd(8'h2D, error_flag_register(transmit_error_counter, receive_error_counter));
        cmp1(efrr, transmit_error_counter >= 128 || receive_error_counter >= 128);
    endtask
    // Received frame with stuffing; bad flips the last CRC bit,
    // the mismatch is flagged at the CRC delimiter
    task automatic frame(input logic [7:0] d, input logic bad);
        logic [22:0] b;
        logic lv;
        int run;
        b = {d, crc8(d) ^ {14'h0000, bad}};
        tick(cedc_pkg::CEDC_F_SOF, 0, 0, 0, 1, 0);
        lv = 1'b0;
        run = 1;
        for (int i = 22; i >= 0; i--) begin
            tick(i > 14 ? cedc_pkg::CEDC_F_DATA : cedc_pkg::CEDC_F_CRC,
                0, 0, 0, !b[i], 0);
            run = b[i] == lv ? run + 1 : 1;
            lv = b[i];
            if (run == 5) begin
                tick(cedc_pkg::CEDC_F_CRC, 0, 0, 1, lv, 0);
                lv = !lv;
                run = 1;
            end
        end
        tick(cedc_pkg::CEDC_F_CRC_DELIM, 0, 1, 0, 0, bad);
    endtask

    initial begin
        #400000;
        n_errors++;
        complete_run();
    end
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        cedc_pkg::cedc_field_e f;
        int k;
        n = $urandom(32'h1394B592);
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        state();
        rd(8'h7F, 8'h00);
        wr(8'h1C, 8'h55);
        wr(8'h32, 8'h01);
        rd(8'h32, 8'h01);
        state();
        frame(8'($urandom), 1'b0);
        frame(8'($urandom), 1'b1);
        receive_error_counter = 1;
        cmp1(irq, 1'b1);
        rd(8'h30, 8'h01);
        wr(8'h31, 8'h01);
        @(posedge sys_clk);
        #1 cmp1(irq, 1'b0);
        tick(cedc_pkg::CEDC_F_SOF, 0, 0, 0, 1, 0);
        for (int i = 1; i <= 5; i++) begin
            tick(cedc_pkg::CEDC_F_ARB, 0, 0, 0, 1, i == 5);
        end
        receive_error_counter = 2;
        state();
        while (receive_error_counter < 128) begin
            k = $urandom_range(2);
            f = cedc_pkg::cedc_field_e'(4'h8 + 4'(k));
            tick(f, 0, 1, 0, 1, 1);
            receive_error_counter++;
            state();
        end
        strobe(1);
        receive_error_counter = 120;
        state();
        tick(cedc_pkg::CEDC_F_SOF, 1, 0, 0, 0, 0);
        tick(cedc_pkg::CEDC_F_ARB, 1, 1, 0, 1, 0);
        ack_en <= 1'b1;
        tick(cedc_pkg::CEDC_F_ACK_SLOT, 1, 1, 0, 0, 0);
        strobe(0);
        ack_en <= 1'b0;
        state();
        while (transmit_error_counter < 256) begin
            k = $urandom_range(2);
            f = k == 0 ? cedc_pkg::CEDC_F_ACK_SLOT : k == 1 ?
                cedc_pkg::CEDC_F_DATA : cedc_pkg::CEDC_F_EOF;
            tick(f, 1, 1, 0, k != 0, 1);
            transmit_error_counter = (k == 0 && transmit_error_counter >= 128) ? transmit_error_counter : transmit_error_counter + 8;
            state();
        end
        cmp1(bus_off, 1'b1);
        tick(cedc_pkg::CEDC_F_DATA, 1, 1, 0, 1, 0);
        for (int i = 0; i < 9; i++) begin
            tick(cedc_pkg::CEDC_F_IDLE, 0, 1, 0, i == 2, 0);
            cmp1(bus_off, i < 8);
        end
        transmit_error_counter = 0;
        receive_error_counter = 0;
        state();
        f0 <= 1'b1;
        strobe(2);
        ovf = 2'b01;
        stb <= 1'b1;
        strobe(2);
        rd(8'h2D, error_flag_register(0, 0));
        f1 <= 1'b1;
        strobe(2);
        ovf = 2'b11;
        rd(8'h2D, error_flag_register(0, 0));
        wr(8'h2D, 8'h3F);
        ovf = 2'b00;
        rd(8'h2D, error_flag_register(0, 0));
        complete_run();
    end
endmodule
